// ---- hw/spcd_pkg.sv ----
/*
 Package for the pass-through command decoder: word offsets within the
 parameter block, option bit positions, command codes, group lengths,
 status layout and the structs that carry decoded results.
 Assumes a 16-bit word view of the parameter block in shared memory.
*/
package spcd_pkg;
   // ----------------------------------------------------------------
   // Block layout
   // ----------------------------------------------------------------
   localparam logic [7:0]  WORD_CODE      = 8'h00;
   localparam logic [7:0]  WORD_OPTIONS   = 8'h01;
   localparam logic [7:0]  WORD_RETSTAT   = 8'h02;
   localparam logic [7:0]  WORD_CDB       = 8'h10;
   localparam logic [7:0]  WORD_SG_LO     = 8'h0C;
   localparam logic [7:0]  WORD_SG_HI     = 8'h0D;
   localparam logic [7:0]  WORD_SENSE_END = 8'h8F;
   localparam logic [7:0]  BLOCK_OVERHEAD = 8'h10;
   // ----------------------------------------------------------------
   // Option bits and return status word bits
   // ----------------------------------------------------------------
   localparam int OPT_INT_EN   = 0;
   localparam int OPT_SG       = 1;
   localparam int OPT_NO_SYNC  = 2;
   localparam int OPT_NO_TMO   = 6;
   localparam int OPT_DIR_READ = 8;
   localparam int RSW_VALID    = 0;
   localparam int RSW_ERROR    = 1;
   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [15:0] CMD_PASS      = 16'h0020;
   localparam logic [15:0] CMD_BUS_RESET = 16'h0022;
   localparam logic [15:0] CMD_CTRL_LO   = 16'h0023;
   localparam logic [15:0] CMD_CTRL_HI   = 16'h0053;
   // ----------------------------------------------------------------
   // Lengths and status values
   // ----------------------------------------------------------------
   localparam logic [7:0]  LEN_G0 = 8'h06;
   localparam logic [7:0]  LEN_G1 = 8'h0A;
   localparam logic [7:0]  LEN_G5 = 8'h0C;
   localparam logic [15:0] STAT_OK       = 16'h0000;
   localparam logic [15:0] STAT_BAD_GRP  = 16'h0001;
   localparam logic [15:0] STAT_BAD_CMD  = 16'h0002;
   localparam logic [15:0] RSW_RESET     = 16'h0000;
   localparam logic [3:0]  CDB_WORDS_MAX = 4'h6;

   typedef enum logic [1:0] {
      SPCD_K_PASS  = 2'h0,
      SPCD_K_RESET = 2'h1,
      SPCD_K_CTRL  = 2'h2,
      SPCD_K_BAD   = 2'h3
   } spcd_kind_e;

   typedef struct packed {
      logic        int_en;
      logic        scatter;
      logic        no_sync;
      logic        no_timeout;
      logic        dir_read;
   } spcd_opts_s;

   typedef struct packed {
      logic       bad_group;
      logic [7:0] cdb_len;
   } spcd_len_s;
endpackage

// ---- hw/spcd_grp_len.sv ----
/*
 Group code length decoder: turns command byte zero and the host block
 length into a descriptor byte count or a reserved-group flag.
 Assumes purely combinational use from the decoder.
*/
`timescale 1ns/1ps
module spcd_grp_len (
   input  wire logic [7:0]         cdb_byte0,
   input  wire logic [7:0]         block_len_words,
   output spcd_pkg::spcd_len_s     len_out
);
   logic [7:0] user_words;

   always_comb begin
      user_words        = block_len_words - spcd_pkg::BLOCK_OVERHEAD;
      len_out.bad_group = 1'b0;
      len_out.cdb_len   = spcd_pkg::LEN_G0;
      case (cdb_byte0[7:5])
         3'd0: len_out.cdb_len = spcd_pkg::LEN_G0;
         3'd1, 3'd2: len_out.cdb_len = spcd_pkg::LEN_G1;
         3'd5: len_out.cdb_len = spcd_pkg::LEN_G5;
         3'd3, 3'd4: len_out.bad_group = 1'b1;
         default: len_out.cdb_len = {user_words[6:0], 1'b0};
      endcase
   end
endmodule

// ---- hw/spcd_top.sv ----
/*
 Pass-through command decoder. Reads a parameter block word by word
 from shared memory, classifies the command, decodes options and the
 descriptor length, streams command bytes to the target side, writes
 the return status and response valid flag, and drives the VMEbus
 completion interrupt with a cause-dependent vector.
 Assumes single-cycle synchronous memory reads and a target side that
 reports done on a pulse.
*/
`timescale 1ns/1ps
module spcd_top (
   input  wire logic               clk_sys,
   input  wire logic               resetn,
   // Command start
   input  wire logic               cmd_go,
   input  wire logic [7:0]         block_len_words,
   input  wire logic               from_priority_slot,
   // Shared memory port
   output logic                    mem_rd,
   output logic                    mem_wr,
   output logic [7:0]              mem_addr,
   output logic [15:0]             mem_wdata,
   input  wire logic [15:0]        mem_rdata,
   // Host clears the response valid flag
   input  wire logic               response_valid_flag_clr,
   // Target side
   output logic                    cdb_valid,
   output logic [7:0]              cdb_byte,
   output logic                    cdb_last,
   output logic                    local_action,
   output logic                    bus_reset_req,
   output logic                    no_sync,
   output logic                    scatter_mode,
   output logic                    no_timeout,
   output logic                    dir_read,
   input  wire logic               target_done,
   input  wire logic               target_err,
   // VMEbus interrupt
   input  wire logic [7:0]         normal_vector,
   input  wire logic [7:0]         error_vector,
   output logic                    irq_req,
   input  wire logic               iack_done,
   output logic [7:0]              irq_vector,
   output logic                    response_valid_flag,
   output logic                    busy
);
   typedef enum logic [2:0] {
      SPCD_IDLE  = 3'b000,
      SPCD_CODE  = 3'b001,
      SPCD_OPTS  = 3'b011,
      SPCD_CDB   = 3'b010,
      SPCD_WAIT  = 3'b110,
      SPCD_STAT  = 3'b111,
      SPCD_HOLD  = 3'b101
   } spcd_state_e;

   spcd_state_e            state_r, state_nxt;
   spcd_pkg::spcd_kind_e   kind_r, kind_nxt;
   spcd_pkg::spcd_opts_s   opts_r, opts_nxt;
   spcd_pkg::spcd_len_s    glen;
   logic [7:0]             cnt_r, cnt_nxt;
   logic [7:0]             len_r, len_nxt;
   logic [7:0]             blen_r, blen_nxt;
   logic                   err_r, err_nxt;
   logic                   rsv_r, rsv_nxt;
   logic                   irq_r, irq_nxt;
   logic [7:0]             vec_r, vec_nxt;
   logic                   cdv_r, cdv_nxt;
   logic [7:0]             cdb_r, cdb_nxt;
   logic                   cdl_r, cdl_nxt;
   logic [7:0]             lo_r, lo_nxt;
   logic                   half_r, half_nxt;
   logic                   rd_r, rd_nxt;
   logic                   wr_r, wr_nxt;
   logic [7:0]             addr_r, addr_nxt;
   logic [15:0]            wd_r, wd_nxt;
   logic [15:0]            code_w;

   spcd_grp_len u_grp (
      .cdb_byte0       (mem_rdata[15:8]),
      .block_len_words (blen_r),
      .len_out         (glen)
   );

   assign code_w = mem_rdata;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      kind_nxt  = kind_r;
      opts_nxt  = opts_r;
      cnt_nxt   = cnt_r;
      len_nxt   = len_r;
      blen_nxt  = blen_r;
      err_nxt   = err_r;
      rsv_nxt   = rsv_r;
      irq_nxt   = irq_r;
      vec_nxt   = vec_r;
      cdv_nxt   = 1'b0;
      cdb_nxt   = cdb_r;
      cdl_nxt   = 1'b0;
      lo_nxt    = lo_r;
      half_nxt  = half_r;
      rd_nxt    = 1'b0;
      wr_nxt    = 1'b0;
      addr_nxt  = addr_r;
      wd_nxt    = wd_r;
      if (response_valid_flag_clr && !(state_r == SPCD_STAT && !wr_r && !rsv_r)) begin
         rsv_nxt = 1'b0;
      end
      if (iack_done) begin
         irq_nxt = 1'b0;
      end
      case (state_r)
         SPCD_IDLE: begin
            if (cmd_go) begin
               blen_nxt  = block_len_words;
               rd_nxt    = 1'b1;
               addr_nxt  = spcd_pkg::WORD_CODE;
               state_nxt = SPCD_CODE;
            end
         end
         SPCD_CODE: begin
            if (!rd_r) begin
               err_nxt = 1'b0;
               if (code_w == spcd_pkg::CMD_PASS) begin
                  kind_nxt = spcd_pkg::SPCD_K_PASS;
               end else if (code_w == spcd_pkg::CMD_BUS_RESET) begin
                  kind_nxt = spcd_pkg::SPCD_K_RESET;
               end else if (code_w >= spcd_pkg::CMD_CTRL_LO && code_w <= spcd_pkg::CMD_CTRL_HI
                            && from_priority_slot) begin
                  kind_nxt = spcd_pkg::SPCD_K_CTRL;
               end else begin
                  kind_nxt = spcd_pkg::SPCD_K_BAD;
                  err_nxt  = 1'b1;
               end
               rd_nxt    = 1'b1;
               addr_nxt  = spcd_pkg::WORD_OPTIONS;
               state_nxt = SPCD_OPTS;
            end
         end
         SPCD_OPTS: begin
            if (!rd_r) begin
               opts_nxt.int_en     = mem_rdata[spcd_pkg::OPT_INT_EN];
               opts_nxt.scatter    = mem_rdata[spcd_pkg::OPT_SG];
               opts_nxt.no_sync    = mem_rdata[spcd_pkg::OPT_NO_SYNC];
               opts_nxt.no_timeout = mem_rdata[spcd_pkg::OPT_NO_TMO];
               opts_nxt.dir_read   = mem_rdata[spcd_pkg::OPT_DIR_READ];
               if (kind_r == spcd_pkg::SPCD_K_PASS) begin
                  rd_nxt    = 1'b1;
                  addr_nxt  = spcd_pkg::WORD_CDB;
                  cnt_nxt   = 8'h00;
                  half_nxt  = 1'b0;
                  state_nxt = SPCD_CDB;
               end else begin
                  state_nxt = SPCD_WAIT;
               end
            end
         end
         SPCD_CDB: begin
            if (!rd_r && !half_r) begin
               if (cnt_r == 8'h00) begin
                  len_nxt = glen.cdb_len;
                  if (glen.bad_group) begin
                     err_nxt   = 1'b1;
                     state_nxt = SPCD_STAT;
                  end
               end
               if (!(cnt_r == 8'h00 && glen.bad_group)) begin
                  cdv_nxt  = 1'b1;
                  cdb_nxt  = mem_rdata[15:8];
                  lo_nxt   = mem_rdata[7:0];
                  half_nxt = 1'b1;
                  cnt_nxt  = cnt_r + 8'h01;
                  cdl_nxt  = (cnt_r == 8'h00) ? (glen.cdb_len == 8'h01)
                                              : (cnt_r + 8'h01 == len_r);
                  if (cdl_nxt) begin
                     state_nxt = SPCD_WAIT;
                  end
               end
            end else if (half_r) begin
               cdv_nxt  = 1'b1;
               cdb_nxt  = lo_r;
               half_nxt = 1'b0;
               cnt_nxt  = cnt_r + 8'h01;
               cdl_nxt  = (cnt_r + 8'h01 == len_r);
               if (cdl_nxt) begin
                  state_nxt = SPCD_WAIT;
               end else begin
                  rd_nxt   = 1'b1;
                  addr_nxt = addr_r + 8'h01;
               end
            end
         end
         SPCD_WAIT: begin
            if (kind_r == spcd_pkg::SPCD_K_BAD) begin
               state_nxt = SPCD_STAT;
            end else if (target_done) begin
               err_nxt   = target_err;
               state_nxt = SPCD_STAT;
            end
         end
         SPCD_STAT: begin
            if (!rsv_r && !irq_r) begin
               wr_nxt    = 1'b1;
               addr_nxt  = spcd_pkg::WORD_RETSTAT;
               wd_nxt    = err_r ? ((kind_r == spcd_pkg::SPCD_K_BAD) ? spcd_pkg::STAT_BAD_CMD
                                                                     : spcd_pkg::STAT_BAD_GRP)
                                 : spcd_pkg::STAT_OK;
               rsv_nxt   = 1'b1;
               irq_nxt   = opts_r.int_en;
               vec_nxt   = err_r ? error_vector : normal_vector;
               state_nxt = SPCD_HOLD;
            end
         end
         SPCD_HOLD: begin
            state_nxt = SPCD_IDLE;
         end
         default: state_nxt = SPCD_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state_r <= SPCD_IDLE;
         kind_r  <= spcd_pkg::SPCD_K_PASS;
         opts_r  <= '0;
         cnt_r   <= 8'h00;
         len_r   <= 8'h00;
         blen_r  <= 8'h00;
         err_r   <= 1'b0;
         rsv_r   <= 1'b0;
         irq_r   <= 1'b0;
         vec_r   <= 8'h00;
         cdv_r   <= 1'b0;
         cdb_r   <= 8'h00;
         cdl_r   <= 1'b0;
         lo_r    <= 8'h00;
         half_r  <= 1'b0;
         rd_r    <= 1'b0;
         wr_r    <= 1'b0;
         addr_r  <= 8'h00;
         wd_r    <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         kind_r  <= kind_nxt;
         opts_r  <= opts_nxt;
         cnt_r   <= cnt_nxt;
         len_r   <= len_nxt;
         blen_r  <= blen_nxt;
         err_r   <= err_nxt;
         rsv_r   <= rsv_nxt;
         irq_r   <= irq_nxt;
         vec_r   <= vec_nxt;
         cdv_r   <= cdv_nxt;
         cdb_r   <= cdb_nxt;
         cdl_r   <= cdl_nxt;
         lo_r    <= lo_nxt;
         half_r  <= half_nxt;
         rd_r    <= rd_nxt;
         wr_r    <= wr_nxt;
         addr_r  <= addr_nxt;
         wd_r    <= wd_nxt;
      end
   end

   assign mem_rd              = rd_r;
   assign mem_wr              = wr_r;
   assign mem_addr            = addr_r;
   assign mem_wdata           = wd_r;
   assign cdb_valid           = cdv_r;
   assign cdb_byte            = cdb_r;
   assign cdb_last            = cdl_r;
   assign local_action        = (kind_r == spcd_pkg::SPCD_K_CTRL) && state_r == SPCD_WAIT;
   assign bus_reset_req       = (kind_r == spcd_pkg::SPCD_K_RESET) && state_r == SPCD_WAIT;
   assign no_sync             = opts_r.no_sync;
   assign scatter_mode        = opts_r.scatter;
   assign no_timeout          = opts_r.no_timeout;
   assign dir_read            = opts_r.dir_read;
   assign irq_req             = irq_r;
   assign irq_vector          = vec_r;
   assign response_valid_flag = rsv_r;
   assign busy                = state_r != SPCD_IDLE;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_IRQ_NEEDS_VALID: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(irq_r) |-> rsv_r) else $error("irq without valid flag");
   AST_IRQ_GATED: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(irq_r) |-> opts_r.int_en) else $error("irq while disabled");
   AST_IACK_DROP: assert property (@(posedge clk_sys) disable iff (!resetn)
      iack_done |=> !irq_r) else $error("irq held after ack");
   AST_NO_REPOST: assert property (@(posedge clk_sys) disable iff (!resetn)
      (rsv_r && !$rose(rsv_r)) |-> !$rose(irq_r)) else $error("repost before clear");
   AST_STATUS_ADDR: assert property (@(posedge clk_sys) disable iff (!resetn)
      wr_r |-> addr_r == spcd_pkg::WORD_RETSTAT) else $error("bad status addr");
   AST_VALID_SET: assert property (@(posedge clk_sys) disable iff (!resetn)
      wr_r |-> rsv_r) else $error("status without valid");
   AST_VEC_CAUSE: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(irq_r) |-> vec_r == (err_r ? $past(error_vector) : $past(normal_vector)))
      else $error("wrong vector");
   AST_CDB_START: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state_r == SPCD_OPTS && state_nxt == SPCD_CDB) |=> addr_r == spcd_pkg::WORD_CDB)
      else $error("cdb not at word 16");
   AST_CDB_COUNT: assert property (@(posedge clk_sys) disable iff (!resetn)
      cdl_r |-> cnt_r == len_r) else $error("cdb length mismatch");
   COV_IRQ: cover property (@(posedge clk_sys) $rose(irq_r));
   COV_CDB_LAST: cover property (@(posedge clk_sys) cdl_r);
   COV_ERR: cover property (@(posedge clk_sys) wr_r && err_r);
endmodule

// ---- verif/spcd_far_model.sv ----
/*
 Far-side model for the pass-through decoder: shared parameter block
 memory plus a SCSI target that ends each command with a done pulse.
 Assumes the bench loads and inspects mem and the byte log directly.
*/
`timescale 1ns/1ps
module spcd_far_model (
   input  wire logic        clk_sys,
   input  wire logic        mem_rd,
   input  wire logic        mem_wr,
   input  wire logic [7:0]  mem_addr,
   input  wire logic [15:0] mem_wdata,
   output logic [15:0]      mem_rdata,
   input  wire logic        cdb_valid,
   input  wire logic [7:0]  cdb_byte,
   input  wire logic        cdb_last,
   input  wire logic        local_action,
   input  wire logic        bus_reset_req,
   input  wire logic        log_clr,
   input  wire logic        err_mode,
   output logic             target_done,
   output logic             target_err
);
   logic [15:0] mem [0:255];
   logic [7:0]  cap [0:15];
   logic [7:0]  cnt;
   logic        saw_local;
   logic        saw_reset;
   logic        pend;
   logic        req_d;
   logic [3:0]  dly;

   initial begin
      mem_rdata   = 16'h0000;
      target_done = 1'b0;
      target_err  = 1'b1;
      pend        = 1'b0;
      req_d       = 1'b0;
      dly         = 4'h0;
   end

   // -------------------------------------------------------------
   // Memory port and target behaviour
   // -------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (mem_rd) mem_rdata <= mem[mem_addr];
      if (mem_wr) mem[mem_addr] <= mem_wdata;
      req_d       <= local_action | bus_reset_req;
      target_done <= 1'b0;
      // Error line is only meaningful with done, so it is junk otherwise
      target_err  <= ~err_mode;
      if (cdb_last || ((local_action | bus_reset_req) && !req_d)) begin
         pend <= 1'b1;
         dly  <= 4'h5;
      end else if (pend) begin
         if (dly == 4'h0) begin
            pend        <= 1'b0;
            target_done <= 1'b1;
            target_err  <= err_mode;
         end else begin
            dly <= dly - 4'h1;
         end
      end
      if (log_clr) begin
         cnt       <= 8'h00;
         saw_local <= 1'b0;
         saw_reset <= 1'b0;
      end else begin
         saw_local <= saw_local | local_action;
         saw_reset <= saw_reset | bus_reset_req;
         if (cdb_valid) begin
            cap[cnt[3:0]] <= cdb_byte;
            cnt           <= cnt + 8'h01;
         end
      end
   end
endmodule

// ---- verif/tb.sv ----
/*
 Self-checking bench for the pass-through decoder: table of commands,
 then reset, interlock and refused-start cases by hand.
 Assumes spcd_far_model stands in for shared memory and the target.
*/
`timescale 1ns/1ps
module tb;
   typedef struct packed {
      logic [15:0] code;
      logic        slot;
      logic [7:0]  b0;
      logic [7:0]  blen;
      logic [15:0] opts;
      logic        terr;
      logic [7:0]  cnt;
      logic [15:0] stat;
      logic        chk;
      logic        err;
   } spcd_row_s;

   logic clk_sys = 1'b0, resetn = 1'b0, cmd_go = 1'b0, from_priority_slot = 1'b0;
   logic [7:0] block_len_words = 8'h00;
   logic response_valid_flag_clr = 1'b0, iack_done = 1'b0, log_clr = 1'b0, err_mode = 1'b0;
   logic [7:0] normal_vector = 8'hA5, error_vector = 8'h5A;
   logic mem_rd, mem_wr, cdb_valid, cdb_last, local_action, bus_reset_req, no_sync;
   logic scatter_mode, no_timeout, dir_read, target_done, target_err, irq_req;
   logic response_valid_flag, busy;
   logic [7:0] mem_addr, cdb_byte, irq_vector;
   logic [15:0] mem_wdata, mem_rdata;
   int failures = 0, compares = 0, k;

   spcd_row_s rows [14] = '{
      '{16'h0020, 1'b0, 8'h08, 8'h30, 16'h0001, 1'b0, 8'd6,  16'h0000, 1'b1, 1'b0},
      '{16'h0020, 1'b0, 8'h28, 8'h30, 16'h0003, 1'b0, 8'd10, 16'h0000, 1'b1, 1'b0},
      '{16'h0020, 1'b0, 8'h5A, 8'h00, 16'h0005, 1'b0, 8'd10, 16'h0000, 1'b1, 1'b0},
      '{16'h0020, 1'b0, 8'hA8, 8'h30, 16'h0141, 1'b0, 8'd12, 16'h0000, 1'b1, 1'b0},
      '{16'h0020, 1'b0, 8'hC0, 8'h16, 16'h0101, 1'b0, 8'd12, 16'h0000, 1'b1, 1'b0},
      '{16'h0020, 1'b0, 8'hE0, 8'h13, 16'h0000, 1'b0, 8'd6,  16'h0000, 1'b1, 1'b0},
      '{16'h0020, 1'b0, 8'h60, 8'h30, 16'h0001, 1'b0, 8'd0,  16'h0001, 1'b1, 1'b1},
      '{16'h0020, 1'b0, 8'h80, 8'h30, 16'h0001, 1'b0, 8'd0,  16'h0001, 1'b1, 1'b1},
      '{16'h0020, 1'b0, 8'h08, 8'h30, 16'h0001, 1'b1, 8'd6,  16'h0001, 1'b1, 1'b1},
      '{16'h0041, 1'b1, 8'h00, 8'h00, 16'h0001, 1'b0, 8'd0,  16'h0000, 1'b1, 1'b0},
      '{16'h004B, 1'b1, 8'h00, 8'h00, 16'h0001, 1'b0, 8'd0,  16'h0000, 1'b1, 1'b0},
      '{16'h0042, 1'b0, 8'h00, 8'h00, 16'h0001, 1'b0, 8'd0,  16'h0002, 1'b1, 1'b1},
      '{16'h0022, 1'b0, 8'h00, 8'h00, 16'h0001, 1'b0, 8'd0,  16'h0000, 1'b1, 1'b0},
      '{16'h0099, 1'b1, 8'h00, 8'h00, 16'h0001, 1'b0, 8'd0,  16'h0002, 1'b1, 1'b1}
   };

   always #12.5 clk_sys = ~clk_sys;

   spcd_top dut_u (.clk_sys(clk_sys), .resetn(resetn), .cmd_go(cmd_go),
      .block_len_words(block_len_words), .from_priority_slot(from_priority_slot),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .response_valid_flag_clr(response_valid_flag_clr),
      .cdb_valid(cdb_valid), .cdb_byte(cdb_byte), .cdb_last(cdb_last),
      .local_action(local_action), .bus_reset_req(bus_reset_req), .no_sync(no_sync),
      .scatter_mode(scatter_mode), .no_timeout(no_timeout), .dir_read(dir_read),
      .target_done(target_done), .target_err(target_err), .normal_vector(normal_vector),
      .error_vector(error_vector), .irq_req(irq_req), .iack_done(iack_done),
      .irq_vector(irq_vector), .response_valid_flag(response_valid_flag), .busy(busy));

   spcd_far_model far_u (.clk_sys(clk_sys), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .cdb_valid(cdb_valid), .cdb_byte(cdb_byte), .cdb_last(cdb_last),
      .local_action(local_action), .bus_reset_req(bus_reset_req), .log_clr(log_clr),
      .err_mode(err_mode), .target_done(target_done), .target_err(target_err));

   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   task automatic close_out();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      compares++;
      if (seen !== want) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   function automatic logic [7:0] exp_byte(input logic [7:0] b0, input int i);
      return (i == 0) ? b0 : 8'h10 + 8'(i);
   endfunction

   task automatic wait_until(input int sel, input logic lvl);
      int n;
      for (n = 0; n < 400; n++) begin
         if ((sel == 0 ? response_valid_flag : busy) === lvl) break;
         @(negedge clk_sys);
      end
      check({15'h0000, sel == 0 ? response_valid_flag : busy}, {15'h0000, lvl});
   endtask

   task automatic pulse(input int sel);
      if (sel == 0) cmd_go = 1'b1;
      else if (sel == 1) iack_done = 1'b1;
      else response_valid_flag_clr = 1'b1;
      @(negedge clk_sys);
      if (sel == 0) cmd_go = 1'b0;
      else if (sel == 1) iack_done = 1'b0;
      else response_valid_flag_clr = 1'b0;
   endtask

   task automatic start(input spcd_row_s r);
      int i;
      far_u.mem[0] = r.code;
      far_u.mem[1] = r.opts;
      far_u.mem[2] = 16'hFFFF;
      for (i = 3; i < 16; i++) far_u.mem[i] = 16'h0000;
      for (i = 0; i < 6; i++) far_u.mem[16 + i] = {exp_byte(r.b0, 2 * i), exp_byte(r.b0, 2 * i + 1)};
      block_len_words = r.blen;
      from_priority_slot = r.slot;
      err_mode = r.terr;
      log_clr = 1'b1;
      @(negedge clk_sys);
      log_clr = 1'b0;
      pulse(0);
   endtask

   task automatic run_cmd(input spcd_row_s r, input bit hold);
      int i;
      start(r);
      wait_until(0, 1'b1);
      // Status word lands in memory one edge after the flag rises
      @(negedge clk_sys);
      check({8'h00, far_u.cnt}, {8'h00, r.cnt});
      for (i = 0; i < r.cnt; i++) check({8'h00, far_u.cap[i]}, {8'h00, exp_byte(r.b0, i)});
      if (r.chk) check(far_u.mem[2], r.stat);
      check({15'h0000, irq_req}, {15'h0000, r.opts[0]});
      if (r.opts[0]) check({8'h00, irq_vector}, {8'h00, r.err ? error_vector : normal_vector});
      check({14'h0000, far_u.saw_local, far_u.saw_reset},
            {14'h0000, r.slot && r.code >= 16'h0023 && r.code <= 16'h0053, r.code == 16'h0022});
      if (r.code == 16'h0020)
         check({12'h000, dir_read, no_timeout, no_sync, scatter_mode},
               {12'h000, r.opts[8], r.opts[6], r.opts[2], r.opts[1]});
      if (r.opts[0]) begin
         pulse(1);
         check({15'h0000, irq_req}, 16'h0000);
      end
      if (!hold) begin
         pulse(2);
         check({15'h0000, response_valid_flag}, 16'h0000);
      end
      wait_until(1, 1'b0);
   endtask

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (12) @(negedge clk_sys);
      resetn = 1'b1;
      check({10'h000, irq_req, response_valid_flag, busy, cdb_valid, mem_wr, mem_rd}, 16'h0000);
      $display("reset test done");
      for (k = 0; k < 14; k++) begin
         run_cmd(rows[k], 1'b0);
         $display("row %0d done", k);
      end
      // Second completion must wait for the host to clear the flag
      run_cmd(rows[0], 1'b1);
      start(rows[1]);
      repeat (60) @(negedge clk_sys);
      check({8'h00, far_u.cnt}, 16'h000A);
      check({13'h0000, irq_req, response_valid_flag, busy}, 16'h0003);
      check(far_u.mem[2], 16'hFFFF);
      pulse(0);
      pulse(2);
      wait_until(0, 1'b1);
      check({15'h0000, irq_req}, 16'h0001);
      pulse(1);
      pulse(2);
      wait_until(1, 1'b0);
      repeat (30) @(negedge clk_sys);
      check({14'h0000, response_valid_flag, busy}, 16'h0000);
      $display("interlock test done");
      // Reset in mid-command returns every output to idle
      start(rows[1]);
      repeat (6) @(negedge clk_sys);
      resetn = 1'b0;
      repeat (2) @(negedge clk_sys);
      resetn = 1'b1;
      check({10'h000, irq_req, response_valid_flag, busy, cdb_valid, mem_wr, mem_rd}, 16'h0000);
      repeat (20) @(negedge clk_sys);
      run_cmd(rows[2], 1'b0);
      $display("mid-run reset test done");
      close_out();
   end

   initial begin
      #(25 * 40000);
      failures++;
      close_out();
   end
endmodule
